// *** verification/liu_global_control_regs_tb.sv ***
`timescale 1ns/1ps
module liu_global_control_regs_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] ch_irq_in = 8'h00;
  logic [1:0] general_pin_in = 2'h2;
  logic [7:0] reg_rdata_q, ch_wr_en_q, ch_wr_data_q, channel_interrupt_flags_q;
  logic [4:0] ch_wr_offset_q;
  logic [3:0] monitor_select_q;
  logic [1:0] general_pin_out_q, general_pin_oe_q, e;
  logic       sw_reset_q, line_standard_select_q, irq_pin_out_q, irq_pin_oe_q;
  logic [7:0] v, a;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;

  lgc_global_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ch_irq_in(ch_irq_in),
    .ch_wr_en_q(ch_wr_en_q), .ch_wr_offset_q(ch_wr_offset_q), .ch_wr_data_q(ch_wr_data_q),
    .sw_reset_q(sw_reset_q), .line_standard_select_q(line_standard_select_q),
    .monitor_select_q(monitor_select_q), .channel_interrupt_flags_q(channel_interrupt_flags_q),
    .irq_pin_out_q(irq_pin_out_q), .irq_pin_oe_q(irq_pin_oe_q),
    .general_pin_in(general_pin_in), .general_pin_out_q(general_pin_out_q),
    .general_pin_oe_q(general_pin_oe_q));

  // free-running clock, 8 ns
  always #4 clk = ~clk;

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one-cycle write strobe; returns once the slave has taken it
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_q);
  endtask

  // write then read the same address with no gap between the strobes
  task automatic wr_rchk(input string what, input logic [7:0] ad, input logic [7:0] d,
                         input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // expected {oe, out} of the interrupt pin
  function automatic logic [1:0] irq_exp(input logic [1:0] s, input logic act);
    if (!s[0]) return {act, 1'b0};
    if (!s[1]) return {1'b1, ~act};
    return {1'b1, act};
  endfunction

  // input pins read the pad, output pins their written level
  function automatic logic [7:0] pin_rd(input logic [3:0] w, input logic [1:0] p);
    return {4'h0, w[1] ? p[1] : w[3], w[0] ? p[0] : w[2], w[1:0]};
  endfunction

  initial begin
    void'($urandom(32'h381d));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    idle(4);
    rchk("config0", 8'h40, 8'h04);
    rchk("config1", 8'h60, 8'h00);
    rchk("int source", 8'h80, 8'h00);
    rchk("pin ctrl", 8'ha0, pin_rd(4'h3, 2'h2));
    rchk("unmapped", 8'hc0, 8'h00);
    chk("pin oe", {6'h0, general_pin_oe_q}, 8'h00);
    $display("test defaults finished");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'hdf; // reserved bit5 kept clear
      wr_rchk("config0", 8'h40, v, v & 8'h1f);
      chk("line std", {7'h0, line_standard_select_q}, {7'h0, v[4]});
    end
    for (int m = 0; m < 16; m++) begin
      wr(8'h60, {4'(m), 4'($urandom)});
      chk("monitor", {4'h0, monitor_select_q}, 8'(m));
      rchk("config1", 8'h60, {4'(m), 4'h0});
    end
    $display("test config finished");
    // copy off then on; first two writes hit the slot window edges
    for (int i = 0; i < 12; i++) begin
      if (i == 0) wr(8'h40, 8'h04);
      if (i == 6) wr(8'h40, 8'h0c);
      a = {3'($urandom), (i % 6 == 0) ? 5'h01 : (i % 6 == 1) ? 5'h1a : 5'($urandom % 26 + 1)};
      v = 8'($urandom);
      wr(a, v);
      chk("ch en", ch_wr_en_q, (i < 6) ? 8'h01 << a[7:5] : 8'hff);
      chk("ch offset", {3'h0, ch_wr_offset_q}, {3'h0, a[4:0]});
      chk("ch data", ch_wr_data_q, v);
      idle(1);
      chk("ch en end", ch_wr_en_q, 8'h00);
    end
    wr(8'h60, 8'h00);
    chk("global fwd", ch_wr_en_q, 8'h00);
    $display("test broadcast finished");
    @(posedge clk) ch_irq_in <= 8'h10;
    idle(4);
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < 4; s++) begin
        wr(8'h40, {5'h0, 1'(g), 2'(s)});
        e = irq_exp(2'(s), g == 0);
        chk("irq oe", {7'h0, irq_pin_oe_q}, {7'h0, e[1]});
        chk("irq out", {7'h0, irq_pin_out_q}, {7'h0, e[0]});
      end
    end
    chk("int flags", channel_interrupt_flags_q, 8'h10);
    wr(8'h40, 8'h03);
    wr(8'h1d, 8'h00);
    chk("masked out", {7'h0, irq_pin_out_q}, 8'h00);
    @(posedge clk) ch_irq_in <= 8'h00;
    wr(8'h1c, 8'hff);
    wr(8'h1d, 8'hff);
    idle(1);
    chk("cleared out", {7'h0, irq_pin_out_q}, 8'h00);
    rchk("status", 8'h1b, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      @(posedge clk) ch_irq_in <= v;
      idle(2);
      rchk("int source", 8'h80, v);
    end
    $display("test interrupts finished");
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom);
      @(posedge clk) general_pin_in <= 2'($urandom);
      wr(8'ha0, {4'h0, a[3:0]});
      idle(3);
      chk("pin oe", {6'h0, general_pin_oe_q}, {6'h0, ~a[1:0]});
      chk("pin out", {6'h0, general_pin_out_q}, {6'h0, a[3:2]});
      rchk("pin ctrl", 8'ha0, pin_rd(a[3:0], general_pin_in));
    end
    $display("test pins finished");
    wr(8'h40, 8'h1b);
    wr(8'h60, 8'hf0);
    wr(8'ha0, 8'h0c);
    wr(8'h20, 8'($urandom));
    chk("sw reset", {7'h0, sw_reset_q}, 8'h01);
    chk("reset fwd", ch_wr_en_q, 8'h00);
    chk("reset oe", {6'h0, general_pin_oe_q}, 8'h00);
    idle(1);
    chk("sw reset end", {7'h0, sw_reset_q}, 8'h00);
    rchk("config0", 8'h40, 8'h04);
    rchk("config1", 8'h60, 8'h00);
    rchk("pin ctrl", 8'ha0, pin_rd(4'h3, general_pin_in));
    rchk("status", 8'h1b, 8'h00);
    $display("test soft reset finished");
    end_of_test();
  end
endmodule

// *** verilog/lgc_global_ctrl.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - any reset-register write restores all defaults
// - config0 bit4 picks E1 or T1/J1
// - copy bit broadcasts channel writes to all
// - global disable bit blocks all interrupts
// - two-bit field sets interrupt pin style
// - config1 bits7-4 choose monitored channel
// - indication bit n shows channel n+1 interrupt
// - output pin drives its level bit
// - input pin level reads back in bit
// - direction bits: 0 output, 1 input
module lgc_global_ctrl (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  input  wire logic [7:0] ch_irq_in,
  output logic      [7:0] ch_wr_en_q,
  output logic      [4:0] ch_wr_offset_q,
  output logic      [7:0] ch_wr_data_q,
  output logic            sw_reset_q,
  output logic            line_standard_select_q,
  output logic      [3:0] monitor_select_q,
  output logic      [7:0] channel_interrupt_flags_q,
  output logic            irq_pin_out_q,
  output logic            irq_pin_oe_q,
  input  wire logic [1:0] general_pin_in,
  output logic      [1:0] general_pin_out_q,
  output logic      [1:0] general_pin_oe_q
);

  // address decode
  logic [4:0] offset;
  logic [2:0] ch_idx;
  logic       ch_reg_hit;
  logic       soft_reset_wr;
  assign offset        = reg_addr[4:0];
  assign ch_idx        = reg_addr[7:5];
  assign ch_reg_hit    = (offset >= lgc_pkg::CH_REG_FIRST) && (offset <= lgc_pkg::CH_REG_LAST);
  assign soft_reset_wr = reg_wr && (reg_addr == lgc_pkg::SOFT_RESET_ADDR);

  // register state
  logic       copy_q, copy_d;
  logic       gint_dis_q, gint_dis_d;
  logic [1:0] pin_style_q, pin_style_d;
  logic       line_std_d;
  logic [3:0] mon_d;
  logic [1:0] pin_val_d, pin_oe_d;
  logic [7:0] evt_status_q, evt_status_d;
  logic [7:0] evt_enable_q, evt_enable_d;
  logic [7:0] ch_int_d;
  logic [7:0] irq_prev_q;
  logic [7:0] rdata_d;
  logic [7:0] ch_wr_en_d;
  logic       irq_active;
  logic       irq_out_d, irq_oe_d;
  logic [1:0] gp_sync1_q, gp_sync2_q;
  logic [7:0] ch_rise;

  assign ch_rise = ch_irq_in & ~irq_prev_q;

  // next values of the software-visible registers
  always_comb begin
    line_std_d   = line_standard_select_q;
    copy_d       = copy_q;
    gint_dis_d   = gint_dis_q;
    pin_style_d  = pin_style_q;
    mon_d        = monitor_select_q;
    pin_val_d    = general_pin_out_q;
    pin_oe_d     = general_pin_oe_q;
    evt_enable_d = evt_enable_q;
    // set wins over clear so a rising edge in the clear cycle survives
    evt_status_d = evt_status_q;
    if (reg_wr && reg_addr == lgc_pkg::EVT_CLEAR_ADDR) begin
      evt_status_d = evt_status_q & ~reg_wdata;
    end
    evt_status_d = evt_status_d | ch_rise;
    ch_int_d     = ch_irq_in;
    if (reg_wr) begin
      case (reg_addr)
        lgc_pkg::GCFG0_ADDR: begin
          line_std_d  = reg_wdata[lgc_pkg::LINE_STD_BIT];
          copy_d      = reg_wdata[lgc_pkg::COPY_BIT];
          gint_dis_d  = reg_wdata[lgc_pkg::GINT_DIS_BIT];
          pin_style_d = reg_wdata[lgc_pkg::PIN_STYLE_LSB +: 2];
        end
        lgc_pkg::GCFG1_ADDR: begin
          mon_d = reg_wdata[lgc_pkg::MON_LSB +: 4];
        end
        lgc_pkg::PIN_CTRL_ADDR: begin
          pin_val_d = {reg_wdata[lgc_pkg::PIN1_VAL_BIT], reg_wdata[lgc_pkg::PIN0_VAL_BIT]};
          // direction 0 means output, so enable is the inverse
          pin_oe_d  = ~{reg_wdata[lgc_pkg::PIN1_DIR_BIT], reg_wdata[lgc_pkg::PIN0_DIR_BIT]};
        end
        lgc_pkg::EVT_ENABLE_ADDR: begin
          evt_enable_d = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    // software reset overrides everything else
    if (soft_reset_wr) begin
      line_std_d   = lgc_pkg::LINE_STD_RST;
      copy_d       = lgc_pkg::COPY_RST;
      gint_dis_d   = lgc_pkg::GINT_DIS_RST;
      pin_style_d  = lgc_pkg::PIN_STYLE_RST;
      mon_d        = lgc_pkg::MON_RST;
      pin_val_d    = lgc_pkg::PIN_VAL_RST;
      pin_oe_d     = lgc_pkg::PIN_OE_RST;
      evt_enable_d = lgc_pkg::EVT_ENABLE_RST;
      evt_status_d = 8'h00;
      ch_int_d     = lgc_pkg::CH_INT_RST;
    end
  end

  // per-channel write forwarding; globals never broadcast
  always_comb begin
    ch_wr_en_d = 8'h00;
    if (reg_wr && ch_reg_hit && !soft_reset_wr) begin
      if (copy_q) begin
        ch_wr_en_d = 8'hff;
      end else begin
        ch_wr_en_d = 8'h01 << ch_idx;
      end
    end
  end

  // interrupt pin from next state so the pin lines up with the registers
  always_comb begin
    irq_active = (|(evt_status_d & evt_enable_d)) && !gint_dis_d;
    irq_out_d  = 1'b0;
    irq_oe_d   = irq_active;
    if (pin_style_d == lgc_pkg::PIN_STYLE_PP_LOW) begin
      irq_out_d = !irq_active;
      irq_oe_d  = 1'b1;
    end else if (pin_style_d == lgc_pkg::PIN_STYLE_PP_HIGH) begin
      irq_out_d = irq_active;
      irq_oe_d  = 1'b1;
    end
  end

  // read mux; data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        lgc_pkg::GCFG0_ADDR: begin
          rdata_d[lgc_pkg::LINE_STD_BIT]        = line_standard_select_q;
          rdata_d[lgc_pkg::COPY_BIT]            = copy_q;
          rdata_d[lgc_pkg::GINT_DIS_BIT]        = gint_dis_q;
          rdata_d[lgc_pkg::PIN_STYLE_LSB +: 2]  = pin_style_q;
        end
        lgc_pkg::GCFG1_ADDR: begin
          rdata_d[lgc_pkg::MON_LSB +: 4] = monitor_select_q;
        end
        lgc_pkg::CH_INT_SRC_ADDR: begin
          rdata_d = channel_interrupt_flags_q;
        end
        lgc_pkg::PIN_CTRL_ADDR: begin
          // input pins read the synchronised pin level
          rdata_d[lgc_pkg::PIN1_VAL_BIT] = general_pin_oe_q[1] ? general_pin_out_q[1]
                                                               : gp_sync2_q[1];
          rdata_d[lgc_pkg::PIN0_VAL_BIT] = general_pin_oe_q[0] ? general_pin_out_q[0]
                                                               : gp_sync2_q[0];
          rdata_d[lgc_pkg::PIN1_DIR_BIT] = !general_pin_oe_q[1];
          rdata_d[lgc_pkg::PIN0_DIR_BIT] = !general_pin_oe_q[0];
        end
        lgc_pkg::EVT_STATUS_ADDR: begin
          rdata_d = evt_status_q;
        end
        lgc_pkg::EVT_ENABLE_ADDR: begin
          rdata_d = evt_enable_q;
        end
        default: begin
          rdata_d = 8'h00; // unmapped and write-only read zero
        end
      endcase
    end
  end

  // register everything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_standard_select_q    <= lgc_pkg::LINE_STD_RST;
      copy_q                    <= lgc_pkg::COPY_RST;
      gint_dis_q                <= lgc_pkg::GINT_DIS_RST;
      pin_style_q               <= lgc_pkg::PIN_STYLE_RST;
      monitor_select_q          <= lgc_pkg::MON_RST;
      general_pin_out_q         <= lgc_pkg::PIN_VAL_RST;
      general_pin_oe_q          <= lgc_pkg::PIN_OE_RST;
      evt_status_q              <= 8'h00;
      evt_enable_q              <= lgc_pkg::EVT_ENABLE_RST;
      channel_interrupt_flags_q <= lgc_pkg::CH_INT_RST;
      irq_prev_q                <= 8'h00;
      reg_rdata_q               <= 8'h00;
      ch_wr_en_q                <= 8'h00;
      ch_wr_offset_q            <= 5'h00;
      ch_wr_data_q              <= 8'h00;
      sw_reset_q                <= 1'b0;
      irq_pin_out_q             <= 1'b0;
      irq_pin_oe_q              <= 1'b0;
      gp_sync1_q                <= 2'h0;
      gp_sync2_q                <= 2'h0;
    end else begin
      line_standard_select_q    <= line_std_d;
      copy_q                    <= copy_d;
      gint_dis_q                <= gint_dis_d;
      pin_style_q               <= pin_style_d;
      monitor_select_q          <= mon_d;
      general_pin_out_q         <= pin_val_d;
      general_pin_oe_q          <= pin_oe_d;
      evt_status_q              <= evt_status_d;
      evt_enable_q              <= evt_enable_d;
      channel_interrupt_flags_q <= ch_int_d;
      irq_prev_q                <= ch_irq_in;
      reg_rdata_q               <= rdata_d;
      ch_wr_en_q                <= ch_wr_en_d;
      ch_wr_offset_q            <= offset;
      ch_wr_data_q              <= reg_wdata;
      sw_reset_q                <= soft_reset_wr;
      irq_pin_out_q             <= irq_out_d;
      irq_pin_oe_q              <= irq_oe_d;
      gp_sync1_q                <= general_pin_in;
      gp_sync2_q                <= gp_sync1_q;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence gcfg0_write_s;
    reg_wr && reg_addr == lgc_pkg::GCFG0_ADDR;
  endsequence

  sequence ch_write_s;
    reg_wr && ch_reg_hit && !soft_reset_wr;
  endsequence

  soft_reset_a: assert property (soft_reset_wr |=> sw_reset_q && gint_dis_q
      && !line_standard_select_q && monitor_select_q == 4'h0 && general_pin_oe_q == 2'h0
      && evt_status_q == 8'h00 && !copy_q)
    else $error("soft reset did not restore defaults");

  line_std_a: assert property (gcfg0_write_s |=>
      line_standard_select_q == $past(reg_wdata[lgc_pkg::LINE_STD_BIT]))
    else $error("line standard not taken from bit 4");

  broadcast_on_a: assert property (ch_write_s ##0 copy_q |=> ch_wr_en_q == 8'hff
      && ch_wr_data_q == $past(reg_wdata))
    else $error("broadcast write did not reach all channels");

  broadcast_off_a: assert property (ch_write_s ##0 !copy_q |=>
      ch_wr_en_q == (8'h01 << $past(ch_idx)))
    else $error("single channel write misrouted");

  gint_block_a: assert property (gint_dis_q && pin_style_q == lgc_pkg::PIN_STYLE_PP_HIGH
      |-> !irq_pin_out_q)
    else $error("interrupt seen while globally disabled");

  open_drain_a: assert property (!pin_style_q[0] |-> !irq_pin_out_q
      && irq_pin_oe_q == ((|(evt_status_q & evt_enable_q)) && !gint_dis_q))
    else $error("open drain pin style wrong");

  monitor_a: assert property (reg_wr && reg_addr == lgc_pkg::GCFG1_ADDR |=>
      monitor_select_q == $past(reg_wdata[7:4]))
    else $error("monitor select not written");

  chan_flags_a: assert property (reg_rd && reg_addr == lgc_pkg::CH_INT_SRC_ADDR |=>
      reg_rdata_q == $past(channel_interrupt_flags_q))
    else $error("channel indication read wrong");

  pin_drive_a: assert property (reg_wr && reg_addr == lgc_pkg::PIN_CTRL_ADDR
      && !reg_wdata[lgc_pkg::PIN1_DIR_BIT] |=> general_pin_oe_q[1]
      && general_pin_out_q[1] == $past(reg_wdata[lgc_pkg::PIN1_VAL_BIT]))
    else $error("output pin level not driven");

  pin_read_a: assert property (reg_rd && reg_addr == lgc_pkg::PIN_CTRL_ADDR
      && !general_pin_oe_q[0] |=> reg_rdata_q[lgc_pkg::PIN0_VAL_BIT] == $past(gp_sync2_q[0]))
    else $error("input pin level not read back");

  pin_dir_a: assert property (reg_wr && reg_addr == lgc_pkg::PIN_CTRL_ADDR |=>
      general_pin_oe_q == ~$past(reg_wdata[1:0]))
    else $error("pin direction wrong");

  reserved_a: assert property (gcfg0_write_s ##1 reg_rd && reg_addr == lgc_pkg::GCFG0_ADDR
      |=> reg_rdata_q[7:5] == 3'h0 && ch_wr_en_q == 8'h00)
    else $error("reserved bits not zero");

endmodule

// *** verilog/lgc_pkg.sv ***
package lgc_pkg;
  // global register offsets
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h20;
  localparam logic [7:0] GCFG0_ADDR      = 8'h40;
  localparam logic [7:0] GCFG1_ADDR      = 8'h60;
  localparam logic [7:0] CH_INT_SRC_ADDR = 8'h80;
  localparam logic [7:0] PIN_CTRL_ADDR   = 8'ha0;
  // channel event status, clear and enable
  localparam logic [7:0] EVT_STATUS_ADDR = 8'h1b;
  localparam logic [7:0] EVT_CLEAR_ADDR  = 8'h1c;
  localparam logic [7:0] EVT_ENABLE_ADDR = 8'h1d;

  // per-channel register window inside each 32-byte slot
  localparam logic [4:0] CH_REG_FIRST = 5'h01;
  localparam logic [4:0] CH_REG_LAST  = 5'h1a;

  // global_config_0 fields
  localparam int LINE_STD_BIT  = 4;
  localparam int COPY_BIT      = 3;
  localparam int GINT_DIS_BIT  = 2;
  localparam int PIN_STYLE_LSB = 0;
  // global_config_1 field
  localparam int MON_LSB       = 4;
  // general_pin_control fields
  localparam int PIN1_VAL_BIT  = 3;
  localparam int PIN0_VAL_BIT  = 2;
  localparam int PIN1_DIR_BIT  = 1;
  localparam int PIN0_DIR_BIT  = 0;

  // reset values
  localparam logic       LINE_STD_RST   = 1'h0;
  localparam logic       COPY_RST       = 1'h0;
  localparam logic       GINT_DIS_RST   = 1'h1;
  localparam logic [1:0] PIN_STYLE_RST  = 2'h0;
  localparam logic [3:0] MON_RST        = 4'h0;
  localparam logic [7:0] CH_INT_RST     = 8'h00;
  localparam logic [1:0] PIN_VAL_RST    = 2'h0;
  localparam logic [1:0] PIN_OE_RST     = 2'h0;
  localparam logic [7:0] EVT_ENABLE_RST = 8'hff;

  // interrupt pin styles; any even code is open drain active low
  localparam logic [1:0] PIN_STYLE_PP_LOW  = 2'h1;
  localparam logic [1:0] PIN_STYLE_PP_HIGH = 2'h3;
endpackage
